/* acs_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_analog_model (
    input  wire logic [3:0]  i_mux_sel,
    input  wire logic [11:0] i_dac_code,
    input  wire logic [11:0] i_level [0:8],
    output logic             o_cmp
);
    // keep the trial bit while the input sits at or above the trial code
    always_comb begin
        if (i_mux_sel <= 4'h8) begin
            o_cmp = (i_level[i_mux_sel] >= i_dac_code);
        end else begin
            // no input routed: give a moving pattern, not a stale level
            o_cmp = ^i_dac_code;
        end
    end
endmodule
`default_nettype wire

/* acs_map.svh */
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// register byte offsets
`define ACS_OFF_CTRL      8'h00
`define ACS_OFF_CHEN      8'h04
`define ACS_OFF_STAT      8'h08
`define ACS_OFF_MASK      8'h0C
`define ACS_OFF_LOW       8'h10
`define ACS_OFF_HIGH      8'h14
`define ACS_OFF_NEXT      8'h18
`define ACS_OFF_DBG       8'h1C
`define ACS_OFF_SMP_BASE  8'h20
`define ACS_OFF_RES_BASE  8'h40
// ctrl fields
`define ACS_CTRL_EN       0
`define ACS_CTRL_SCAN     1
`define ACS_CTRL_FW       2
`define ACS_CTRL_TRIG     3
`define ACS_CTRL_TEMP     4
`define ACS_CTRL_REF_LO   8
`define ACS_CTRL_DIV_LO   16
// status bits
`define ACS_ST_DONE       0
`define ACS_ST_RANGE      1
`define ACS_ST_EOS        2
// reset values
`define ACS_RST_HIGH      12'hFFF
`define ACS_RST_SMP       8'h02
`define ACS_RST_DIV       8'h01
// timing
`define ACS_CONV_CLKS     18
`define ACS_CLK_HZ        20000000
`define ACS_CONV_MAX_HZ   14500000
`define ACS_SLVERR        2'h2
`endif

/* acs_pkg.sv */
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_REF_VDD,
        ACS_REF_VDD_HALF,
        ACS_REF_INT_1V024,
        ACS_REF_EXT_PIN
    } acs_ref_t;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT
    } acs_state_t;
endpackage

/* acs_sequencer.sv */
// Contract
// - A 12-bit conversion lasts at least 18 converter clocks and the converter clock stays at or below 14.5 MHz.
// - Eight fixed input channels exist and a per-channel enable chooses which join a scan.
// - Scan mode steps the enabled channels by itself with no idle cycle between channels.
// - The next channel is picked either by the internal state machine or directly by firmware.
// - Each channel has its own result buffer readable at any time.
// - Sample time is programmable per channel and the current channel's value is used.
// - Programmable low and high limits raise an out-of-range interrupt for results outside them.
// - The range check runs on each result as it completes, not at scan end.
// - Reference select offers supply, half supply, 1.024 V internal or an external pin.
// - The sample-and-hold aperture is programmable to give slow drivers more settling time.
// - The temperature sensor is selectable as a conversion input like a channel; this design takes it only in firmware mode, never in a scan.
// - In deep low-power or retention state the converter is idle with nothing in progress.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "acs_map.svh"
`default_nettype none
module acs_sequencer #(
    parameter int NCH = 8,
    parameter int RW  = 12
) (
    input  wire logic          i_clk,
    input  wire logic          i_sys_rst,
    input  wire logic          i_deep_sleep,
    input  wire logic [31:0]   i_awaddr,
    input  wire logic          i_awvalid,
    output logic               o_awready,
    input  wire logic [31:0]   i_wdata,
    input  wire logic [3:0]    i_wstrb,
    input  wire logic          i_wvalid,
    output logic               o_wready,
    output logic [1:0]         o_bresp,
    output logic               o_bvalid,
    input  wire logic          i_bready,
    input  wire logic [31:0]   i_araddr,
    input  wire logic          i_arvalid,
    output logic               o_arready,
    output logic [31:0]        o_rdata,
    output logic [1:0]         o_rresp,
    output logic               o_rvalid,
    input  wire logic          i_rready,
    output logic               o_conv_clk,
    output logic [3:0]         o_mux_sel,
    output logic               o_sample,
    output logic [1:0]         o_ref_sel,
    output logic [RW-1:0]      o_dac_code,
    input  wire logic          i_cmp,
    output logic               o_irq
);
    localparam int CONV_MIN_DIV = (`ACS_CLK_HZ + `ACS_CONV_MAX_HZ - 1) / `ACS_CONV_MAX_HZ;
    localparam logic [7:0] DIV_MIN = 8'(CONV_MIN_DIV);
    localparam logic [3:0] TEMP_SEL = 4'(NCH);

    function automatic logic [2:0] next_en(input logic [NCH-1:0] en, input logic [2:0] cur);
        logic [2:0] r;
        logic       f;
        r = cur;
        f = 1'b0;
        for (int k = 1; k <= NCH; k++) begin
            if (!f && en[3'(cur + 3'(k))]) begin
                r = 3'(cur + 3'(k));
                f = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic is_last(input logic [NCH-1:0] en, input logic [2:0] cur);
        return next_en(en, cur) <= cur;
    endfunction

    // register state
    logic [31:0]         ctrl_reg, ctrl_next;
    logic [NCH-1:0]      chen_reg, chen_next;
    logic [2:0]          stat_reg, stat_next;
    logic [2:0]          mask_reg, mask_next;
    logic [RW-1:0]       low_reg, low_next, high_reg, high_next;
    logic [2:0]          fwch_reg, fwch_next;
    logic [7:0]          smp_reg [NCH];
    logic [7:0]          smp_next [NCH];
    logic [RW-1:0]       res_reg [NCH+1];
    logic [RW-1:0]       res_next [NCH+1];
    logic                bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]          bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]         rdata_reg, rdata_next;
    // sequencer state
    acs_pkg::acs_state_t st_reg, st_next;
    logic [2:0]          ch_reg, ch_next;
    logic                tmp_reg, tmp_next;
    logic [7:0]          div_reg, div_next;
    logic                cclk_reg, cclk_next;
    logic [7:0]          cnt_reg, cnt_next;
    logic [4:0]          bit_reg, bit_next;
    logic [RW-1:0]       trial_reg, trial_next;
    logic                pend_reg, pend_next;

    logic        wr_go, rd_go, tick, run, fw_mode;
    logic [7:0]  div_set;
    logic [7:0]  waddr, raddr;
    assign wr_go   = i_awvalid && i_wvalid && !bvalid_reg;
    assign rd_go   = i_arvalid && !rvalid_reg;
    assign waddr   = i_awaddr[7:0];
    assign raddr   = i_araddr[7:0];
    assign run     = ctrl_reg[`ACS_CTRL_EN] && !i_deep_sleep;
    assign fw_mode = ctrl_reg[`ACS_CTRL_FW];
    // divider floor keeps the converter clock legal whatever software writes
    assign div_set = (ctrl_reg[`ACS_CTRL_DIV_LO +: 8] < DIV_MIN) ? DIV_MIN : ctrl_reg[`ACS_CTRL_DIV_LO +: 8];
    assign tick    = run && (div_reg == 8'h00) && cclk_reg;

    always_comb begin
        logic        done;
        logic [RW-1:0] res;
        logic        lastc;
        logic [2:0]  setv;
        done = 1'b0;
        res = '0;
        lastc = 1'b0;
        setv = '0;
        ctrl_next = ctrl_reg;
        chen_next = chen_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        low_next = low_reg;
        high_next = high_reg;
        fwch_next = fwch_reg;
        smp_next = smp_reg;
        res_next = res_reg;
        bvalid_next = bvalid_reg && !i_bready;
        rvalid_next = rvalid_reg && !i_rready;
        bresp_next = bresp_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        st_next = st_reg;
        ch_next = ch_reg;
        tmp_next = tmp_reg;
        pend_next = pend_reg;
        div_next = (div_reg == 8'h00) ? 8'(div_set - 8'h01) : 8'(div_reg - 8'h01);
        cclk_next = (div_reg == 8'h00) ? !cclk_reg : cclk_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        trial_next = trial_reg;
        ctrl_next[`ACS_CTRL_TRIG] = 1'b0;
        if (!run) begin
            st_next = acs_pkg::ACS_IDLE;
            // restart always opens with a full low phase
            div_next = 8'(div_set - 8'h01);
            cclk_next = 1'b0;
        end else if (tick) begin
            case (st_reg)
                acs_pkg::ACS_IDLE: begin
                    if ((!fw_mode && ctrl_reg[`ACS_CTRL_SCAN] && chen_reg != '0) || pend_reg) begin
                        st_next = acs_pkg::ACS_SAMPLE;
                        pend_next = 1'b0;
                        tmp_next = fw_mode && ctrl_reg[`ACS_CTRL_TEMP];
                        ch_next = fw_mode ? fwch_reg : next_en(chen_reg, 3'(NCH - 1));
                        cnt_next = 8'h00;
                    end
                end
                acs_pkg::ACS_SAMPLE: begin
                    cnt_next = 8'(cnt_reg + 8'h01);
                    if (cnt_reg >= smp_reg[ch_reg]) begin
                        st_next = acs_pkg::ACS_CONVERT;
                        bit_next = 5'(RW - 1);
                        trial_next = '0;
                        cnt_next = 8'h00;
                    end
                end
                acs_pkg::ACS_CONVERT: begin
                    cnt_next = 8'(cnt_reg + 8'h01);
                    if (cnt_reg < 8'(RW))
                        trial_next[bit_reg[3:0]] = i_cmp;
                    if (cnt_reg < 8'(RW - 1))
                        bit_next = 5'(bit_reg - 5'h01);
                    // successive steps done by RW, pad to the full conversion length
                    if (cnt_reg == 8'(`ACS_CONV_CLKS - 1)) begin
                        done = 1'b1;
                        res = trial_reg;
                        lastc = !fw_mode && is_last(chen_reg, ch_reg);
                        if (!fw_mode && ctrl_reg[`ACS_CTRL_SCAN] && chen_reg != '0) begin
                            st_next = acs_pkg::ACS_SAMPLE;
                            ch_next = next_en(chen_reg, ch_reg);
                            tmp_next = 1'b0;
                        end else begin
                            st_next = acs_pkg::ACS_IDLE;
                        end
                        cnt_next = 8'h00;
                    end
                end
                default: st_next = acs_pkg::ACS_IDLE;
            endcase
        end
        if (done) begin
            res_next[tmp_reg ? NCH : 32'(ch_reg)] = res;
            setv[`ACS_ST_DONE] = 1'b1;
            if (res < low_reg || res > high_reg)
                setv[`ACS_ST_RANGE] = 1'b1;
            if (lastc)
                setv[`ACS_ST_EOS] = 1'b1;
        end
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next = 2'h0;
            case (waddr)
                `ACS_OFF_CTRL: begin
                    ctrl_next = i_wdata;
                    // trigger may arrive together with the enable
                    if (i_wdata[`ACS_CTRL_TRIG] && i_wdata[`ACS_CTRL_EN] && !i_deep_sleep)
                        pend_next = 1'b1;
                end
                `ACS_OFF_CHEN: chen_next = i_wdata[NCH-1:0];
                `ACS_OFF_STAT: stat_next = stat_reg & ~i_wdata[2:0];
                `ACS_OFF_MASK: mask_next = i_wdata[2:0];
                `ACS_OFF_LOW:  low_next = i_wdata[RW-1:0];
                `ACS_OFF_HIGH: high_next = i_wdata[RW-1:0];
                `ACS_OFF_NEXT: fwch_next = i_wdata[2:0];
                default: begin
                    if (waddr >= `ACS_OFF_SMP_BASE && waddr < 8'(`ACS_OFF_SMP_BASE + 8'(4 * NCH)))
                        smp_next[waddr[4:2]] = i_wdata[7:0];
                    else
                        bresp_next = `ACS_SLVERR;
                end
            endcase
        end
        // a same-cycle event wins over the clear
        stat_next = stat_next | setv;
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next = 2'h0;
            rdata_next = 32'h0;
            case (raddr)
                `ACS_OFF_CTRL: rdata_next = ctrl_reg;
                `ACS_OFF_CHEN: rdata_next = 32'(chen_reg);
                `ACS_OFF_STAT: rdata_next = 32'(stat_reg);
                `ACS_OFF_MASK: rdata_next = 32'(mask_reg);
                `ACS_OFF_LOW:  rdata_next = 32'(low_reg);
                `ACS_OFF_HIGH: rdata_next = 32'(high_reg);
                `ACS_OFF_NEXT: rdata_next = 32'(fwch_reg);
                `ACS_OFF_DBG:  rdata_next = {24'h0, 1'b0, tmp_reg, st_reg, ch_reg, run};
                default: begin
                    if (raddr >= `ACS_OFF_SMP_BASE && raddr < 8'(`ACS_OFF_SMP_BASE + 8'(4 * NCH)))
                        rdata_next = 32'(smp_reg[raddr[4:2]]);
                    else if (raddr >= `ACS_OFF_RES_BASE && raddr <= 8'(`ACS_OFF_RES_BASE + 8'(4 * NCH)))
                        rdata_next = 32'(res_reg[raddr[5:2]]);
                    else
                        rresp_next = `ACS_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_reg <= {8'h00, `ACS_RST_DIV, 16'h0000};
            chen_reg <= '0;
            stat_reg <= '0;
            mask_reg <= '0;
            low_reg <= '0;
            high_reg <= `ACS_RST_HIGH;
            fwch_reg <= '0;
            for (int i = 0; i < NCH; i++)
                smp_reg[i] <= `ACS_RST_SMP;
            for (int i = 0; i <= NCH; i++)
                res_reg[i] <= '0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0;
            st_reg <= acs_pkg::ACS_IDLE;
            ch_reg <= '0;
            tmp_reg <= 1'b0;
            div_reg <= 8'h00;
            cclk_reg <= 1'b0;
            cnt_reg <= 8'h00;
            bit_reg <= 5'h00;
            trial_reg <= '0;
            pend_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            chen_reg <= chen_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            low_reg <= low_next;
            high_reg <= high_next;
            fwch_reg <= fwch_next;
            smp_reg <= smp_next;
            res_reg <= res_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            st_reg <= st_next;
            ch_reg <= ch_next;
            tmp_reg <= tmp_next;
            div_reg <= div_next;
            cclk_reg <= cclk_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            trial_reg <= trial_next;
            pend_reg <= pend_next;
        end
    end

    assign o_awready  = wr_go;
    assign o_wready   = wr_go;
    assign o_bvalid   = bvalid_reg;
    assign o_bresp    = bresp_reg;
    assign o_arready  = rd_go;
    assign o_rvalid   = rvalid_reg;
    assign o_rdata    = rdata_reg;
    assign o_rresp    = rresp_reg;
    assign o_conv_clk = cclk_reg;
    assign o_mux_sel  = tmp_reg ? TEMP_SEL : {1'b0, ch_reg};
    assign o_sample   = (st_reg == acs_pkg::ACS_SAMPLE);
    assign o_ref_sel  = ctrl_reg[`ACS_CTRL_REF_LO +: 2];
    assign o_dac_code = trial_reg | (RW'(1) << bit_reg[3:0]);
    assign o_irq      = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

/* acs_sequencer_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_checker (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_deep_sleep,
    input  wire logic        i_awvalid,
    input  wire logic        i_wvalid,
    input  wire logic        o_awready,
    input  wire logic [1:0]  o_bresp,
    input  wire logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire logic [31:0] o_rdata,
    input  wire logic        o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        o_conv_clk,
    input  wire logic [3:0]  o_mux_sel,
    input  wire logic        o_sample
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic       clk_q;
    logic [5:0] tick_cnt;
    logic       armed;
    // bus writes may abort a conversion, so they disarm the length check
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            clk_q    <= 1'b0;
            tick_cnt <= 6'h00;
            armed    <= 1'b0;
        end else begin
            clk_q <= o_conv_clk;
            if ($fell(o_sample)) begin
                tick_cnt <= 6'h00;
                armed    <= 1'b1;
            end else if (i_deep_sleep || i_awvalid) begin
                armed <= 1'b0;
            end else if (o_conv_clk && !clk_q && tick_cnt != 6'h3F) begin
                tick_cnt <= tick_cnt + 6'h01;
            end
        end
    end
    sequence s_wr_take;
        i_awvalid && i_wvalid && o_awready;
    endsequence
    sequence s_rd_take;
        i_arvalid && o_arready;
    endsequence
    // stopping the sequencer may cut a high phase short
    chk_clk_high: assert property ($rose(o_conv_clk) && !i_deep_sleep && !$past(i_awvalid) |=> o_conv_clk)
        else $error("converter clock high phase too short");
    chk_clk_low: assert property ($fell(o_conv_clk) |=> !o_conv_clk)
        else $error("converter clock low phase too short");
    // boundary edge may land on either side of the sample edges
    chk_conv_len: assert property ($rose(o_sample) && armed |-> tick_cnt >= 6'h11)
        else $error("conversion shorter than allowed");
    chk_sleep_idle: assert property (i_deep_sleep [*4] |-> !o_sample && !o_conv_clk)
        else $error("converter active in low power");
    chk_mux_range: assert property (o_sample |-> o_mux_sel <= 4'h8)
        else $error("sampling an unlisted input");
    chk_mux_hold: assert property (o_sample && $past(o_sample) |-> $stable(o_mux_sel))
        else $error("input changed during aperture");
    chk_write_answer: assert property (s_wr_take |=> o_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_rd_take |=> o_rvalid)
        else $error("read response late");
    chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    chk_aw_gate: assert property (o_awready |-> i_awvalid && i_wvalid && !o_bvalid)
        else $error("write ready without both halves");
endmodule
bind acs_sequencer acs_sequencer_checker u_chk (.i_clk, .i_sys_rst, .i_deep_sleep, .i_awvalid, .i_wvalid,
    .o_awready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready,
    .o_conv_clk, .o_mux_sel, .o_sample);
`default_nettype wire

/* tb_adc_channel_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_adc_channel_sequencer;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_deep_sleep = 1'b0, i_cmp;
    logic [31:0] i_awaddr = '0, i_wdata = '0, i_araddr = '0, o_rdata, rd;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_clk, o_sample, o_irq;
    logic [1:0]  o_bresp, o_rresp, o_ref_sel, rs;
    logic [3:0]  o_mux_sel;
    logic [11:0] o_dac_code;
    logic [11:0] level [0:8];
    int          errors = 0, check_count = 0, smp_cnt = 0, smp_last = 0;
    logic        scanning = 1'b0;
    acs_sequencer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_deep_sleep(i_deep_sleep), .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .o_conv_clk(o_conv_clk), .o_mux_sel(o_mux_sel), .o_sample(o_sample),
        .o_ref_sel(o_ref_sel), .o_dac_code(o_dac_code), .i_cmp(i_cmp), .o_irq(o_irq));
    acs_analog_model u_ana (.i_mux_sel(o_mux_sel), .i_dac_code(o_dac_code), .i_level(level), .o_cmp(i_cmp));
    always #25 i_clk = ~i_clk;
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 1000; n++) begin
            @(negedge i_clk);
            if (s === 1'b1) return;
        end
        `CHK(s, 1'b1)
        close_out();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        i_awaddr <= {24'h000000, a};
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        wait_hi(o_awready);
        `CHK(o_wready, 1'b1)
        @(posedge i_clk);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        wait_hi(o_bvalid);
        `CHK(o_bresp, er)
        @(posedge i_clk);
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        i_araddr <= {24'h000000, a};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        wait_hi(o_arready);
        @(posedge i_clk);
        i_arvalid <= 1'b0;
        wait_hi(o_rvalid);
        rd = o_rdata;
        rs = o_rresp;
        @(posedge i_clk);
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic poll(input int b);
        for (int n = 0; n < 300; n++) begin
            axi_rd(`ACS_OFF_STAT);
            if (rd[b] === 1'b1) return;
        end
        `CHK(rd[b], 1'b1)
        close_out();
    endtask
    // aperture length and input choice seen while sampling
    always @(negedge i_clk) begin
        smp_cnt <= (o_sample === 1'b1) ? smp_cnt + 1 : 0;
        if (o_sample !== 1'b1 && smp_cnt != 0) smp_last <= smp_cnt;
        if (scanning && o_sample === 1'b1) `CHK(o_mux_sel inside {4'h2, 4'h5, 4'h7}, 1'b1)
    end
    task automatic t_regs();
        axi_rd(`ACS_OFF_CTRL);
        `CHK(rd, 32'h0001_0000)
        axi_rd(`ACS_OFF_HIGH);
        `CHK(rd, 32'h0000_0FFF)
        axi_rd(`ACS_OFF_SMP_BASE + 8'h14);
        `CHK(rd, 32'h0000_0002)
        axi_rd(8'hF0);
        `CHK({rs, rd}, {`ACS_SLVERR, 32'h0000_0000})
        axi_wr(8'hF0, 32'h0000_0001, `ACS_SLVERR);
        for (int r = 0; r < 4; r++) begin
            axi_wr(`ACS_OFF_CTRL, 32'h0001_0000 | (32'(r) << 8), 2'h0);
            `CHK(o_ref_sel, 2'(r))
        end
    endtask
    task automatic t_fw();
        axi_wr(`ACS_OFF_SMP_BASE + 8'h14, 32'h0000_0005, 2'h0);
        axi_wr(`ACS_OFF_NEXT, 32'h0000_0005, 2'h0);
        axi_wr(`ACS_OFF_CTRL, 32'h0001_000D, 2'h0);
        poll(`ACS_ST_DONE);
        `CHK(smp_last, 24)
        axi_rd(`ACS_OFF_RES_BASE + 8'h14);
        `CHK(rd, {20'h00000, level[5]})
        axi_wr(`ACS_OFF_STAT, 32'h0000_0007, 2'h0);
        axi_wr(`ACS_OFF_CTRL, 32'h0001_001D, 2'h0);
        poll(`ACS_ST_DONE);
        axi_rd(8'h60);
        `CHK(rd, {20'h00000, level[8]})
    endtask
    task automatic t_scan();
        axi_wr(`ACS_OFF_STAT, 32'h0000_0007, 2'h0);
        axi_wr(`ACS_OFF_LOW, 32'h0000_0300, 2'h0);
        axi_wr(`ACS_OFF_HIGH, 32'h0000_0600, 2'h0);
        axi_wr(`ACS_OFF_CHEN, 32'h0000_00A4, 2'h0);
        axi_wr(`ACS_OFF_MASK, 32'h0000_0002, 2'h0);
        scanning = 1'b1;
        axi_wr(`ACS_OFF_CTRL, 32'h0001_0003, 2'h0);
        wait_hi(o_irq);
        @(posedge i_clk);
        axi_rd(`ACS_OFF_STAT);
        // first channel is out of range, so the flag beats end of scan
        `CHK(rd[2:1], 2'b01)
        axi_wr(`ACS_OFF_MASK, 32'h0000_0004, 2'h0);
        wait_hi(o_irq);
        @(posedge i_clk);
        axi_rd(`ACS_OFF_STAT);
        `CHK(rd[2:1], 2'b11)
        for (int c = 2; c < 8; c += (c == 2) ? 3 : 2) begin
            axi_rd(`ACS_OFF_RES_BASE + 8'(4 * c));
            `CHK(rd, {20'h00000, level[c]})
        end
        axi_wr(`ACS_OFF_CTRL, 32'h0001_0000, 2'h0);
        scanning = 1'b0;
        axi_wr(`ACS_OFF_MASK, 32'h0000_0000, 2'h0);
        `CHK(o_irq, 1'b0)
        axi_wr(`ACS_OFF_STAT, 32'h0000_0007, 2'h0);
        axi_wr(`ACS_OFF_MASK, 32'h0000_0004, 2'h0);
        `CHK(o_irq, 1'b0)
        axi_rd(`ACS_OFF_STAT);
        `CHK(rd, 32'h0000_0000)
    endtask
    task automatic t_sleep();
        scanning = 1'b1;
        axi_wr(`ACS_OFF_CTRL, 32'h0001_0003, 2'h0);
        wait_hi(o_sample);
        @(posedge i_clk);
        i_deep_sleep <= 1'b1;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        `CHK({o_sample, o_conv_clk}, 2'b00)
        @(posedge i_clk);
        i_deep_sleep <= 1'b0;
        axi_wr(`ACS_OFF_CTRL, 32'h0001_0000, 2'h0);
        scanning = 1'b0;
    endtask
    initial begin
        for (int n = 0; n < 9; n++) level[n] = 12'(n) * 12'h100 + 12'h0A5;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_fw();
        t_scan();
        t_sleep();
        close_out();
    end
endmodule
`default_nettype wire
